// [core/bfa_pkg.sv]
`default_nettype none
package bfa_pkg;

    // ********************************
    // operating mode and clock rate codes
    // ********************************
    localparam logic [1:0] MODE_OFF   = 2'h0;
    localparam logic [1:0] MODE_ASYNC = 2'h1;
    localparam logic [1:0] MODE_BURST = 2'h2;
    localparam logic [1:0] RATE_DIV1  = 2'h1;
    localparam logic [1:0] RATE_DIV2  = 2'h2;
    localparam logic [1:0] RATE_DIV4  = 2'h3;

    // ********************************
    // request sizes and widths
    // ********************************
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam int SYS_AW  = 28;
    localparam int FL_AW   = 25;
    localparam int FL_DW   = 16;
    localparam int AVL_W   = 4;
    localparam int OEL_W   = 2;
    localparam int LAT_W   = 5;

    // ********************************
    // counts and reset values
    // ********************************
    localparam logic [LAT_W-1:0] LAT_ONE   = 5'h01;
    localparam logic [LAT_W-1:0] LAT_RST   = 5'h00;
    localparam logic [OEL_W-1:0] OEL_RST   = 2'h0;
    localparam logic [1:0]       DIV_RST   = 2'h0;
    localparam logic [15:0]      HALF_RST  = 16'h0000;
    localparam logic [31:0]      WORD_RST  = 32'h0000_0000;
    localparam logic [1:0]       SEC_LOW   = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT = 3'b001,
        ST_AVD  = 3'b010,
        ST_TURN = 3'b011,
        ST_OE   = 3'b100,
        ST_WE   = 3'b101,
        ST_HOLD = 3'b110,
        ST_DONE = 3'b111
    } bfa_state_t;

endpackage
`default_nettype wire

// [core/bfa_tick_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface bfa_tick_if;
    logic [1:0] rate;
    logic       tick;
    logic       mid;
    logic       phase;

    modport div  (input rate, output tick, output mid, output phase);
    modport ctrl (output rate, input tick, input mid, input phase);
endinterface
`default_nettype wire

// [core/bfa_clk_div.sv]
`timescale 1ns/1ps
`default_nettype none
module bfa_clk_div (
    input  wire logic clk,
    input  wire logic rst,
    bfa_tick_if.div   tk
);
    logic [1:0] cnt_r;
    logic [1:0] last;
    logic [1:0] half;

    // RL23 reserved rate code runs at the slowest rate, the safe choice
    always_comb begin
        last = 2'h3;
        half = 2'h2;
        if (tk.rate == bfa_pkg::RATE_DIV1) begin
            last = 2'h0;
            half = 2'h0;
        end else if (tk.rate == bfa_pkg::RATE_DIV2) begin
            last = 2'h1;
            half = 2'h1;
        end
    end

    // ********************************
    // period counter
    // ********************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= bfa_pkg::DIV_RST;
        end else if (cnt_r >= last) begin
            cnt_r <= bfa_pkg::DIV_RST;
        end else begin
            cnt_r <= cnt_r + 2'h1;
        end
    end

    // tick marks a flash clock rising edge, mid the half period
    assign tk.tick  = (cnt_r == bfa_pkg::DIV_RST);
    assign tk.mid   = (cnt_r == half);
    assign tk.phase = (cnt_r < half) || (last == 2'h0);

endmodule // bfa_clk_div
`default_nettype wire

// [core/bfa_ctrl.sv]
// How it works
// RL1: 256M system space, 16-bit flash data, 25-bit flash address, all sizes.
// RL2: every request is answered; the error line never rises.
// RL3: with multiplexing, low sixteen address bits go on the data lines.
// RL4: flash clock is master clock, divided by 2, or divided by 4; undivided, the clock pin stays high in burst mode.
// RL5: address-valid latency up to sixteen; release latency one to three.
// RL6: disabled after reset; active once the mode input selects a mode.
// RL7: asynchronous mode keeps the flash clock pin low.
// RL8: byte, half and word reads; a word read becomes two half reads.
// RL9: only half-word writes are done; other writes are dropped quietly.
// RL10: address on address bus with address-valid pulse, and muxed data.
// RL11: write enable falls in the flash cycle after address valid.
// RL12: reads add one turnaround cycle before output enable.
// RL13: strobe pulse length is latency field plus one flash cycles.
// RL14: an asynchronous read ends as output enable rises.
// RL15: write data and address held half a flash cycle past enable rise; with the undivided clock they are held a whole one.
// RL16: data bus kept reserved for release-latency cycles after a read.
// RL17: muxed write after read waits release latency; other orders never.
// RL18: software sets the clock rate even in asynchronous mode.
// RL19: strobes are active low, ready input is active high.
// RL20: when enabled, drive address, data and select; watch ready.
// RL21: burst advance by clock or by the advance strobe; held idle here.
// RL22: mode codes 00 off, 01 asynchronous, 10 burst read, 11 reserved.
// RL23: rate codes 01 undivided, 10 by two, 11 by four, 00 reserved.
// RL24: word read fetches low half first, result assembled little-endian.
`timescale 1ns/1ps
`default_nettype none
module bfa_ctrl (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        REQ_VALID,
    input  wire logic        REQ_WRITE,
    input  wire logic [1:0]  REQ_SIZE,
    input  wire logic [27:0] REQ_ADDR,
    input  wire logic [31:0] REQ_WDATA,
    output logic             REQ_READY,
    output logic             RSP_VALID,
    output logic [31:0]      RSP_RDATA,
    output logic             RSP_ERROR,
    input  wire logic [1:0]  OPERATING_MODE_SEL,
    input  wire logic [1:0]  CLOCK_RATE_SEL,
    input  wire logic [3:0]  ADDR_VALID_LATENCY,
    input  wire logic [1:0]  OE_RELEASE_LATENCY,
    input  wire logic        MUX_EN,
    output logic             BUS_HELD,
    output logic             FLASH_CLK_OUT,
    output logic             FLASH_CHIP_SEL_N,
    output logic             ADDR_VALID_N,
    output logic             ADDR_ADVANCE_N,
    output logic             OUT_ENABLE_N,
    output logic             WRITE_ENABLE_N,
    input  wire logic        FLASH_READY_IN,
    output logic [24:0]      FLASH_ADDR,
    input  wire logic [15:0] DATA_I,
    output logic [15:0]      DATA_O,
    output logic             DATA_OE_N
);

    // ********************************
    // declarations
    // ********************************
    bfa_pkg::bfa_state_t state_r;
    logic [27:0]  addr_r;
    logic [15:0]  wdata_r;
    logic [1:0]   size_r;
    logic         wr_r;
    logic         second_r;
    logic [15:0]  low_r;
    logic [4:0]   cnt_r;
    logic [1:0]   oel_cnt_r;
    logic         rdy_s1_r;
    logic         rdy_s2_r;
    logic [15:0]  din_s1_r;
    logic [15:0]  din_s2_r;
    logic         active;
    logic [4:0]   lat;
    logic [24:0]  fa_nxt;
    logic         rd_end;
    logic         wr_blocked;
    logic         drop_req;
    logic [31:0]  rdata_nxt;

    bfa_tick_if tif ();

    // RL4 rate select
    // RL23 reserved rate code resolved in the divider
    assign tif.rate = CLOCK_RATE_SEL;

    bfa_clk_div u_div (
        .clk (CLK),
        .rst (RST),
        .tk  (tif.div)
    );

    // ********************************
    // pin synchronisers
    // ********************************
    // RL19 ready sampled as active high
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdy_s1_r <= 1'b0;
            rdy_s2_r <= 1'b0;
            din_s1_r <= bfa_pkg::HALF_RST;
            din_s2_r <= bfa_pkg::HALF_RST;
        end else begin
            rdy_s1_r <= FLASH_READY_IN;
            rdy_s2_r <= rdy_s1_r;
            din_s1_r <= DATA_I;
            din_s2_r <= din_s1_r;
        end
    end

    // ********************************
    // decode of configuration
    // ********************************
    // RL22 mode codes decoded here
    // RL6 reserved mode behaves as disabled
    assign active = (OPERATING_MODE_SEL == bfa_pkg::MODE_ASYNC) ||
                    (OPERATING_MODE_SEL == bfa_pkg::MODE_BURST);

    // RL5 four-bit field reaches sixteen flash cycles
    // RL13 field holds latency minus one
    assign lat = {1'b0, ADDR_VALID_LATENCY} + bfa_pkg::LAT_ONE;

    // RL9 only half-word writes, and none in burst read mode
    assign drop_req = REQ_WRITE &&
                      ((REQ_SIZE != bfa_pkg::SIZE_HALF) ||
                       (OPERATING_MODE_SEL == bfa_pkg::MODE_BURST));

    // ********************************
    // flash address of each half
    // ********************************
    // RL24 second half-word sits at the upper half address of the aligned word
    always_comb begin
        fa_nxt = addr_r[24:0];
        if (second_r) begin
            fa_nxt = {addr_r[24:2], bfa_pkg::SEC_LOW};
        end
    end

    // RL14 read ends on the tick that lifts output enable
    // RL20 ready gates the end of the data phase
    assign rd_end = (state_r == bfa_pkg::ST_OE) && tif.tick &&
                    (cnt_r <= bfa_pkg::LAT_ONE) && rdy_s2_r;

    // RL17 only a multiplexed write waits for the flash to let go
    assign wr_blocked = wr_r && MUX_EN && (oel_cnt_r != bfa_pkg::OEL_RST);

    // ********************************
    // read data assembly
    // ********************************
    // RL8 byte lane pick and word assembly
    always_comb begin
        rdata_nxt = {16'h0000, din_s2_r};
        if (size_r == bfa_pkg::SIZE_BYTE) begin
            rdata_nxt = {24'h00_0000,
                         (addr_r[0] ? din_s2_r[15:8] : din_s2_r[7:0])};
        end else if (size_r == bfa_pkg::SIZE_WORD) begin
            // RL24 low half first, little-endian
            rdata_nxt = {din_s2_r, low_r};
        end
    end

    // ********************************
    // bus release counter
    // ********************************
    // RL16 other masters stay off the data bus while the flash releases
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            oel_cnt_r <= bfa_pkg::OEL_RST;
            BUS_HELD  <= 1'b0;
        end else if (rd_end) begin
            oel_cnt_r <= OE_RELEASE_LATENCY;
            BUS_HELD  <= (OE_RELEASE_LATENCY != bfa_pkg::OEL_RST);
        end else if (tif.tick && (oel_cnt_r != bfa_pkg::OEL_RST)) begin
            oel_cnt_r <= oel_cnt_r - 2'h1;
            BUS_HELD  <= (oel_cnt_r != 2'h1);
        end
    end

    // ********************************
    // flash clock pin
    // ********************************
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            FLASH_CLK_OUT  <= 1'b0;
            ADDR_ADVANCE_N <= 1'b1;
        end else begin
            // RL7 clock runs only in burst read mode
            FLASH_CLK_OUT  <= (OPERATING_MODE_SEL == bfa_pkg::MODE_BURST) &&
                              tif.phase;
            // RL21 advance strobe stays inactive, bursts are not issued
            ADDR_ADVANCE_N <= 1'b1;
        end
    end

    // ********************************
    // access sequencer
    // ********************************
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_r          <= bfa_pkg::ST_IDLE;
            addr_r           <= 28'h000_0000;
            wdata_r          <= bfa_pkg::HALF_RST;
            size_r           <= bfa_pkg::SIZE_BYTE;
            wr_r             <= 1'b0;
            second_r         <= 1'b0;
            low_r            <= bfa_pkg::HALF_RST;
            cnt_r            <= bfa_pkg::LAT_RST;
            // RL19 active-low strobes idle high
            REQ_READY        <= 1'b0;
            RSP_VALID        <= 1'b0;
            RSP_RDATA        <= bfa_pkg::WORD_RST;
            RSP_ERROR        <= 1'b0;
            FLASH_CHIP_SEL_N <= 1'b1;
            ADDR_VALID_N     <= 1'b1;
            OUT_ENABLE_N     <= 1'b1;
            WRITE_ENABLE_N   <= 1'b1;
            FLASH_ADDR       <= 25'h000_0000;
            DATA_O           <= bfa_pkg::HALF_RST;
            DATA_OE_N        <= 1'b1;
        end else begin
            REQ_READY <= 1'b0;
            RSP_VALID <= 1'b0;
            // RL2 no abort is ever signalled
            RSP_ERROR <= 1'b0;
            case (state_r)
                bfa_pkg::ST_IDLE: begin
                    if (REQ_VALID) begin
                        // RL1 full system address kept, flash sees 25 bits
                        REQ_READY <= 1'b1;
                        addr_r    <= REQ_ADDR;
                        wdata_r   <= REQ_WDATA[15:0];
                        size_r    <= REQ_SIZE;
                        wr_r      <= REQ_WRITE;
                        second_r  <= 1'b0;
                        if (!active || drop_req) begin
                            // RL9 dropped writes still complete
                            RSP_VALID <= 1'b1;
                            RSP_RDATA <= bfa_pkg::WORD_RST;
                            state_r   <= bfa_pkg::ST_DONE;
                        end else begin
                            state_r <= bfa_pkg::ST_WAIT;
                        end
                    end
                end
                bfa_pkg::ST_WAIT: begin
                    if (tif.tick && !wr_blocked) begin
                        // RL10 address phase with valid strobe
                        FLASH_CHIP_SEL_N <= 1'b0;
                        ADDR_VALID_N     <= 1'b0;
                        FLASH_ADDR       <= fa_nxt;
                        if (MUX_EN) begin
                            // RL3 low sixteen address bits on data lines
                            DATA_O    <= fa_nxt[15:0];
                            DATA_OE_N <= 1'b0;
                        end
                        state_r <= bfa_pkg::ST_AVD;
                    end
                end
                bfa_pkg::ST_AVD: begin
                    if (tif.tick) begin
                        ADDR_VALID_N <= 1'b1;
                        if (wr_r) begin
                            // RL11 write enable in the next flash cycle
                            WRITE_ENABLE_N <= 1'b0;
                            DATA_O         <= wdata_r;
                            DATA_OE_N      <= 1'b0;
                            cnt_r          <= lat;
                            state_r        <= bfa_pkg::ST_WE;
                        end else begin
                            // RL12 pads turn around before output enable
                            DATA_OE_N <= 1'b1;
                            state_r   <= bfa_pkg::ST_TURN;
                        end
                    end
                end
                bfa_pkg::ST_TURN: begin
                    if (tif.tick) begin
                        OUT_ENABLE_N <= 1'b0;
                        cnt_r        <= lat;
                        state_r      <= bfa_pkg::ST_OE;
                    end
                end
                bfa_pkg::ST_OE: begin
                    if (rd_end) begin
                        OUT_ENABLE_N     <= 1'b1;
                        FLASH_CHIP_SEL_N <= 1'b1;
                        cnt_r            <= bfa_pkg::LAT_RST;
                        if (size_r == bfa_pkg::SIZE_WORD && !second_r) begin
                            // RL8 first half kept, second read follows
                            low_r    <= din_s2_r;
                            second_r <= 1'b1;
                            state_r  <= bfa_pkg::ST_WAIT;
                        end else begin
                            RSP_VALID <= 1'b1;
                            RSP_RDATA <= rdata_nxt;
                            state_r   <= bfa_pkg::ST_DONE;
                        end
                    end else if (tif.tick && cnt_r > bfa_pkg::LAT_ONE) begin
                        // RL13 output enable lasts the latency
                        cnt_r <= cnt_r - bfa_pkg::LAT_ONE;
                    end
                end
                bfa_pkg::ST_WE: begin
                    if (tif.tick) begin
                        if (cnt_r > bfa_pkg::LAT_ONE) begin
                            // RL13 write pulse lasts the latency
                            cnt_r <= cnt_r - bfa_pkg::LAT_ONE;
                        end else begin
                            WRITE_ENABLE_N <= 1'b1;
                            cnt_r          <= bfa_pkg::LAT_RST;
                            state_r        <= bfa_pkg::ST_HOLD;
                        end
                    end
                end
                bfa_pkg::ST_HOLD: begin
                    // RL15 release half a flash cycle after enable rises;
                    // undivided clock cannot split, so it waits a whole one
                    if (tif.mid) begin
                        DATA_OE_N        <= 1'b1;
                        FLASH_CHIP_SEL_N <= 1'b1;
                        RSP_VALID        <= 1'b1;
                        RSP_RDATA        <= bfa_pkg::WORD_RST;
                        state_r          <= bfa_pkg::ST_DONE;
                    end
                end
                bfa_pkg::ST_DONE: begin
                    // gives the requester a cycle to drop its valid line
                    state_r <= bfa_pkg::ST_IDLE;
                end
                default: begin
                    state_r <= bfa_pkg::ST_IDLE;
                end
            endcase
        end
    end

endmodule // bfa_ctrl
`default_nettype wire

// [verification/bfa_ctrl_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module bfa_ctrl_asserts (
    input wire logic        CLK, RST, REQ_READY, RSP_ERROR,
    input wire logic [1:0]  OPERATING_MODE_SEL, CLOCK_RATE_SEL,
    input wire logic [1:0]  OE_RELEASE_LATENCY,
    input wire logic [3:0]  ADDR_VALID_LATENCY,
    input wire logic        MUX_EN, BUS_HELD, FLASH_CLK_OUT,
    input wire logic        FLASH_CHIP_SEL_N, ADDR_VALID_N, ADDR_ADVANCE_N,
    input wire logic        OUT_ENABLE_N, WRITE_ENABLE_N, DATA_OE_N,
    input wire logic [24:0] FLASH_ADDR,
    input wire logic [15:0] DATA_O
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // ****************
    // strobe length
    // ****************
    logic [6:0] low_cnt_r;
    int         div;
    always_comb begin
        div = (CLOCK_RATE_SEL == bfa_pkg::RATE_DIV1) ? 1 :
              (CLOCK_RATE_SEL == bfa_pkg::RATE_DIV2) ? 2 : 4;
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) low_cnt_r <= 7'h00;
        else if (OUT_ENABLE_N && WRITE_ENABLE_N) low_cnt_r <= 7'h00;
        else low_cnt_r <= low_cnt_r + 7'h01;
    end
    chk_no_abort: assert property (RSP_ERROR == 1'b0)
        else $error("error line raised");
    chk_clock_quiet: assert property (
        OPERATING_MODE_SEL != bfa_pkg::MODE_BURST &&
        $past(OPERATING_MODE_SEL) != bfa_pkg::MODE_BURST |-> !FLASH_CLK_OUT)
        else $error("flash clock runs outside burst mode");
    chk_off_quiet: assert property (
        (OPERATING_MODE_SEL[0] == OPERATING_MODE_SEL[1]) &&
        $stable(OPERATING_MODE_SEL) |-> FLASH_CHIP_SEL_N)
        else $error("select while disabled");
    chk_mux_addr: assert property (
        !ADDR_VALID_N && MUX_EN |-> !DATA_OE_N &&
        DATA_O == FLASH_ADDR[15:0]) else $error("no address on data");
    chk_avd_select: assert property (
        !ADDR_VALID_N |-> !FLASH_CHIP_SEL_N &&
        OUT_ENABLE_N && WRITE_ENABLE_N) else $error("bad address phase");
    chk_we_follows: assert property (
        $fell(WRITE_ENABLE_N) |-> $rose(ADDR_VALID_N))
        else $error("write enable misplaced");
    chk_oe_turn: assert property (
        $fell(OUT_ENABLE_N) |-> ADDR_VALID_N && !$rose(ADDR_VALID_N))
        else $error("no turnaround cycle");
    chk_strobe_len: assert property (
        $rose(OUT_ENABLE_N) || $rose(WRITE_ENABLE_N) |->
        low_cnt_r == (ADDR_VALID_LATENCY + 1) * div)
        else $error("strobe length wrong");
    chk_write_hold: assert property (
        $rose(WRITE_ENABLE_N) |-> !DATA_OE_N ##[1:3] DATA_OE_N)
        else $error("write data hold wrong");
    chk_held_nowrite: assert property (
        BUS_HELD && MUX_EN |-> WRITE_ENABLE_N)
        else $error("write during bus release");
    chk_held_after: assert property (
        $rose(OUT_ENABLE_N) && OE_RELEASE_LATENCY != 2'h0 |-> BUS_HELD)
        else $error("bus not held after read");
    chk_ready_pulse: assert property (REQ_READY |=> !REQ_READY)
        else $error("ready longer than one cycle");
    chk_advance_idle: assert property (ADDR_ADVANCE_N)
        else $error("address advance asserted");
    cover property ($rose(WRITE_ENABLE_N));
    cover property (!ADDR_VALID_N && MUX_EN);
    cover property ($rose(OUT_ENABLE_N) && CLOCK_RATE_SEL == 2'h3);
endmodule // bfa_ctrl_asserts
bind bfa_ctrl bfa_ctrl_asserts u_chk (.*);
`default_nettype wire

// [verification/bfa_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bfa_flash_model (
    input  wire logic        clk,
    input  wire logic        cs_n, avd_n, oe_n, we_n, data_oe_n,
    input  wire logic [24:0] addr,
    input  wire logic [15:0] data_o,
    output logic [15:0]      data_i,
    output logic             ready
);
    logic [15:0] mem [int];
    logic [23:0] adr_r;
    logic        we_d_r;
    assign ready = 1'b1;
    initial data_i = 16'h1234;
    always @(posedge clk) begin
        if (!avd_n) adr_r <= addr[24:1];
        we_d_r <= we_n;
        if (we_n && !we_d_r && !cs_n && !data_oe_n) mem[adr_r] = data_o;
        if (!cs_n && !oe_n)
            data_i <= mem.exists(adr_r) ? mem[adr_r] : adr_r[15:0] ^ 16'ha5c3;
        else
            data_i <= ~data_i;
    end
endmodule // bfa_flash_model
`default_nettype wire

// [verification/test_burst_flash_async_controller.sv]
`timescale 1ns/1ps
`default_nettype none
module test_burst_flash_async_controller;
    logic        clk, rst, req_valid, req_write, mux_en, rdy, req_ready;
    logic        rsp_valid, rsp_error, held, fclk, cs_n, avd_n, adv_n;
    logic        oe_n, we_n, data_oe_n;
    logic [1:0]  req_size, mode, rate, oe_release_latency;
    logic [3:0]  addr_valid_latency;
    logic [27:0] req_addr, a;
    logic [31:0] req_wdata, rsp_rdata, rd, d;
    logic [24:0] faddr;
    logic [15:0] data_i, data_o, h;
    logic [15:0] mem [int];
    int          num_errors, n_compared, seed, cs_lows;
    bfa_ctrl dut (.CLK(clk), .RST(rst), .REQ_VALID(req_valid),
        .REQ_WRITE(req_write), .REQ_SIZE(req_size), .REQ_ADDR(req_addr),
        .REQ_WDATA(req_wdata), .REQ_READY(req_ready), .RSP_VALID(rsp_valid),
        .RSP_RDATA(rsp_rdata), .RSP_ERROR(rsp_error),
        .OPERATING_MODE_SEL(mode), .CLOCK_RATE_SEL(rate),
        .ADDR_VALID_LATENCY(addr_valid_latency), .OE_RELEASE_LATENCY(oe_release_latency), .MUX_EN(mux_en),
        .BUS_HELD(held), .FLASH_CLK_OUT(fclk), .FLASH_CHIP_SEL_N(cs_n),
        .ADDR_VALID_N(avd_n), .ADDR_ADVANCE_N(adv_n), .OUT_ENABLE_N(oe_n),
        .WRITE_ENABLE_N(we_n), .FLASH_READY_IN(rdy), .FLASH_ADDR(faddr),
        .DATA_I(data_i), .DATA_O(data_o), .DATA_OE_N(data_oe_n));
    bfa_flash_model u_flash (.clk(clk), .cs_n(cs_n), .avd_n(avd_n),
        .oe_n(oe_n), .we_n(we_n), .data_oe_n(data_oe_n), .addr(faddr),
        .data_o(data_o), .data_i(data_i), .ready(rdy));
    // ****************
    // helpers
    // ****************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) if (cs_n === 1'b0) cs_lows++;
    task automatic report_and_stop;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one request, held until taken; answer captured at its own edge
    task automatic access(input logic wr, input logic [1:0] sz,
                          input logic [27:0] ad, input logic [31:0] wd);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_size <= sz;
        req_addr <= ad;
        req_wdata <= wd;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 500);
        req_valid <= 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        rd = rsp_rdata;
        repeat (2) @(posedge clk);
    endtask
    function automatic logic [15:0] half(input logic [27:0] ad);
        int k;
        k = int'(ad[24:1]);
        return mem.exists(k) ? mem[k] : ad[16:1] ^ 16'ha5c3;
    endfunction
    initial begin
        repeat (80000) @(posedge clk);
        num_errors++;
        report_and_stop;
    end
    // ****************
    // main sequence
    // ****************
    initial begin
        logic [1:0] quiet [3];
        quiet = '{bfa_pkg::MODE_OFF, 2'h3, bfa_pkg::MODE_BURST};
        seed = 21165;
        {req_valid, req_write, mux_en, req_size, oe_release_latency} = '0;
        {req_addr, req_wdata} = '0;
        mode = bfa_pkg::MODE_OFF;
        rate = bfa_pkg::RATE_DIV1;
        addr_valid_latency = 4'h3;
        rst = 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        a = 28'h0000a40;
        foreach (quiet[i]) begin
            mode <= quiet[i];
            access(1'b1, bfa_pkg::SIZE_HALF, a, $random(seed));
            check("quiet answer", 32'h0, rd);
        end
        check("quiet select", 32'h0, cs_lows);
        mode <= bfa_pkg::MODE_ASYNC;
        access(1'b0, bfa_pkg::SIZE_HALF, a, 32'h0);
        check("untouched half", {16'h0, half(a)}, {16'h0, rd[15:0]});
        for (int r = 1; r < 4; r++) begin
            for (int m = 0; m < 2; m++) begin
                rate <= 2'(r);
                mux_en <= m[0];
                addr_valid_latency <= 4'(3 + {$random(seed)} % 13);
                oe_release_latency <= 2'(1 + {$random(seed)} % 3);
                repeat (2) begin
                    a = {$random(seed)} & 28'h1fffffc;
                    d = $random(seed);
                    access(1'b1, bfa_pkg::SIZE_HALF, a, d);
                    mem[int'(a[24:1])] = d[15:0];
                    access(1'b1, bfa_pkg::SIZE_BYTE, a, ~d);
                    access(1'b1, bfa_pkg::SIZE_WORD, a, ~d);
                    access(1'b0, bfa_pkg::SIZE_HALF, a, 32'h0);
                    check("half", {16'h0, half(a)}, {16'h0, rd[15:0]});
                    access(1'b0, bfa_pkg::SIZE_WORD, a, 32'h0);
                    check("word", {half(a + 2), half(a)}, rd);
                    h = half(a);
                    access(1'b0, bfa_pkg::SIZE_BYTE, a | 28'h1, 32'h0);
                    check("byte", {24'h0, h[15:8]}, rd);
                end
            end
        end
        report_and_stop;
    end
endmodule // test_burst_flash_async_controller
`default_nettype wire
